// [logic/ccs_params.svh]
// constants of the core status register block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_ADDR_STACK      8'h81
`define CCS_ADDR_PTR_LOW    8'h82
`define CCS_ADDR_PTR_HIGH   8'h83
`define CCS_ADDR_STATUS     8'hd0
`define CCS_ADDR_MAIN       8'he0
`define CCS_ADDR_SECOND     8'hf0
`define CCS_RST_STACK       8'h07
`define CCS_RST_PTR_LOW     8'h00
`define CCS_RST_PTR_HIGH    8'h00
`define CCS_RST_STATUS      8'h00
`define CCS_RST_MAIN        8'h00
`define CCS_RST_SECOND      8'h00
`define CCS_BIT_CARRY       3'h7
`define CCS_BIT_AUX         3'h6
`define CCS_BIT_USER_ZERO   3'h5
`define CCS_BIT_BANK_HIGH   3'h4
`define CCS_BIT_BANK_LOW    3'h3
`define CCS_BIT_EXCESS      3'h2
`define CCS_BIT_USER_ONE    3'h1
`define CCS_BIT_PARITY      3'h0
`define CCS_STEP         8'h01
`define CCS_ZERO_BYTE    8'h00
`define CCS_BANK_LOW     3'h0
`endif

// [logic/ccs_pkg.sv]
// types of the core status register block
package ccs_pkg;
	// one special-function access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccs_sfr_req_type;
	// one bit-addressed write from the core
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic       value;
	} ccs_bit_req_type;
	// flag results of the arithmetic unit
	typedef struct packed {
		logic carry_we;
		logic carry;
		logic aux_we;
		logic aux;
		logic excess_we;
		logic excess;
	} ccs_alu_flags_type;
endpackage : ccs_pkg

// [logic/ccs_core_status.sv]
// core stack, pointer, status word and operand registers
//
// Overview of operation
// - After reset the stack top pointer holds 0x07.
// - A push first increments the stack top pointer, and the byte goes to the new location.
// - The 16-bit indirect address pointer is the high byte register over the low byte register.
// - The carry flag in bit 7 takes the carry or borrow of the last arithmetic operation.
// - The auxiliary carry in bit 6 takes the nibble carry or borrow of the last operation.
// - Status bits 4 and 3 select working register bank 0 to 3 at 0x00, 0x08, 0x10, 0x18.
// - The overflow flag in bit 2 takes signed, multiply or divide overflow from the core.
// - Status bit 0 is read-only and always shows odd parity of the main operand register.
// - Status bits 5 and 1 are plain read/write user flags, also writable one bit at a time.
// - The second operand register serves multiply and divide and is bit-addressable at 0xf0.
`timescale 1ns/1ps
`include "ccs_params.svh"

module ccs_core_status (
	// clock and reset
	input  wire logic                       i_mclk,
	input  wire logic                       i_rst_n,
	// special-function register access
	input  wire ccs_pkg::ccs_sfr_req_type   i_sfr,
	input  wire ccs_pkg::ccs_bit_req_type   i_bit,
	output logic                            o_sfr_hit,
	output logic                            o_sfr_ack,
	output logic [7:0]                      o_sfr_rdata,
	// core datapath
	input  wire logic                       i_push,
	input  wire logic                       i_pop,
	input  wire ccs_pkg::ccs_alu_flags_type i_alu,
	input  wire logic                       i_main_we,
	input  wire logic [7:0]                 i_main_wdata,
	input  wire logic                       i_second_we,
	input  wire logic [7:0]                 i_second_wdata,
	// register state
	output logic [7:0]                      o_stack_top,
	output logic [15:0]                     o_indirect_address_pointer,
	output logic [4:0]                      o_bank_base,
	output logic [7:0]                      o_main_operand,
	output logic [7:0]                      o_second_operand,
	output logic                            o_carry_flag,
	output logic                            o_parity
);
	import ccs_pkg::*;

	// byte write then bit write applied to an old value
	function automatic logic [7:0] apply_write(input logic [7:0] old_value,
		input logic byte_we, input logic [7:0] byte_value,
		input logic bit_we, input logic [2:0] bit_idx, input logic bit_value);
		logic [7:0] result;
		result = byte_we ? byte_value : old_value;
		if (bit_we) begin
			result[bit_idx] = bit_value;
		end
		return result;
	endfunction : apply_write

	// bit address falls in the byte at base
	function automatic logic bit_in(input logic [7:0] bit_addr, input logic [7:0] base);
		return bit_addr[7:3] == base[7:3];
	endfunction : bit_in

	logic [7:0] stack_top_pointer;
	logic [7:0] indirect_pointer_low;
	logic [7:0] indirect_pointer_high;
	logic [7:0] program_status_word;
	logic [7:0] main_operand_register;
	logic [7:0] second_operand_register;
	logic       first_cycle;

	// address decode
	wire hit_stack  = i_sfr.addr == `CCS_ADDR_STACK;
	wire hit_low    = i_sfr.addr == `CCS_ADDR_PTR_LOW;
	wire hit_high   = i_sfr.addr == `CCS_ADDR_PTR_HIGH;
	wire hit_status = i_sfr.addr == `CCS_ADDR_STATUS;
	wire hit_main   = i_sfr.addr == `CCS_ADDR_MAIN;
	wire hit_second = i_sfr.addr == `CCS_ADDR_SECOND;
	wire any_hit    = hit_stack | hit_low | hit_high | hit_status | hit_main | hit_second;

	wire bit_status = i_bit.wr & bit_in(i_bit.addr, `CCS_ADDR_STATUS);
	wire bit_main   = i_bit.wr & bit_in(i_bit.addr, `CCS_ADDR_MAIN);
	wire bit_second = i_bit.wr & bit_in(i_bit.addr, `CCS_ADDR_SECOND);

	wire parity_now = ^main_operand_register;

	// stack: a core write wins over push or pop in the same cycle
	wire [7:0] stack_stepped = i_push ? stack_top_pointer + `CCS_STEP :
		(i_pop ? stack_top_pointer - `CCS_STEP : stack_top_pointer);
	wire [7:0] next_stack_top_pointer = (i_sfr.wr & hit_stack) ? i_sfr.wdata :
		stack_stepped;

	wire [7:0] next_indirect_pointer_low = apply_write(indirect_pointer_low,
		i_sfr.wr & hit_low, i_sfr.wdata, 1'b0, i_bit.addr[2:0], i_bit.value);
	wire [7:0] next_indirect_pointer_high = apply_write(indirect_pointer_high,
		i_sfr.wr & hit_high, i_sfr.wdata, 1'b0, i_bit.addr[2:0], i_bit.value);

	// status word: core writes first, arithmetic flag results override
	wire [7:0] status_written = apply_write(program_status_word, i_sfr.wr & hit_status,
		i_sfr.wdata, bit_status, i_bit.addr[2:0], i_bit.value);
	logic [7:0] next_program_status_word;
	always_comb begin
		next_program_status_word = status_written;
		if (i_alu.carry_we) begin
			next_program_status_word[`CCS_BIT_CARRY] = i_alu.carry;
		end
		if (i_alu.aux_we) begin
			next_program_status_word[`CCS_BIT_AUX] = i_alu.aux;
		end
		if (i_alu.excess_we) begin
			next_program_status_word[`CCS_BIT_EXCESS] = i_alu.excess;
		end
		next_program_status_word[`CCS_BIT_PARITY] = 1'b0;
	end

	// operand registers: core register writes win over datapath results
	wire [7:0] main_base = i_main_we ? i_main_wdata : main_operand_register;
	wire [7:0] next_main_operand_register = apply_write(main_base, i_sfr.wr & hit_main,
		i_sfr.wdata, bit_main, i_bit.addr[2:0], i_bit.value);
	wire [7:0] second_base = i_second_we ? i_second_wdata :
		second_operand_register;
	wire [7:0] next_second_operand_register = apply_write(second_base,
		i_sfr.wr & hit_second, i_sfr.wdata, bit_second, i_bit.addr[2:0],
		i_bit.value);

	// read selection
	wire [7:0] status_view = {program_status_word[7:1], parity_now};
	wire [7:0] read_mux = hit_stack ? stack_top_pointer :
		hit_low    ? indirect_pointer_low :
		hit_high   ? indirect_pointer_high :
		hit_status ? status_view :
		hit_main   ? main_operand_register :
		hit_second ? second_operand_register : `CCS_ZERO_BYTE;
	wire [7:0] next_rdata = (i_sfr.rd & any_hit) ? read_mux : `CCS_ZERO_BYTE;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stack_top_pointer       <= `CCS_RST_STACK;
			indirect_pointer_low    <= `CCS_RST_PTR_LOW;
			indirect_pointer_high   <= `CCS_RST_PTR_HIGH;
			program_status_word     <= `CCS_RST_STATUS;
			main_operand_register   <= `CCS_RST_MAIN;
			second_operand_register <= `CCS_RST_SECOND;
		end else begin
			stack_top_pointer       <= next_stack_top_pointer;
			indirect_pointer_low    <= next_indirect_pointer_low;
			indirect_pointer_high   <= next_indirect_pointer_high;
			program_status_word     <= next_program_status_word;
			main_operand_register   <= next_main_operand_register;
			second_operand_register <= next_second_operand_register;
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sfr_rdata <= `CCS_ZERO_BYTE;
			o_sfr_ack   <= 1'b0;
			o_parity    <= 1'b0;
			first_cycle <= 1'b1;
		end else begin
			o_sfr_rdata <= next_rdata;
			o_sfr_ack   <= i_sfr.rd & any_hit;
			o_parity    <= ^next_main_operand_register;
			first_cycle <= 1'b0;
		end
	end

	assign o_sfr_hit                  = any_hit;
	assign o_stack_top                = stack_top_pointer;
	assign o_indirect_address_pointer = {indirect_pointer_high, indirect_pointer_low};
	assign o_bank_base = {program_status_word[`CCS_BIT_BANK_HIGH],
		program_status_word[`CCS_BIT_BANK_LOW], `CCS_BANK_LOW};
	assign o_main_operand             = main_operand_register;
	assign o_second_operand           = second_operand_register;
	assign o_carry_flag               = program_status_word[`CCS_BIT_CARRY];

	property p_reset_stack;
		@(posedge i_mclk) disable iff (!i_rst_n)
		first_cycle |-> stack_top_pointer == `CCS_RST_STACK;
	endproperty
	a_reset_stack: assert property (p_reset_stack) else $error("stack top wrong after reset");

	property p_push;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_push && !(i_sfr.wr && hit_stack)) |=>
			o_stack_top == $past(o_stack_top) + `CCS_STEP;
	endproperty
	a_push: assert property (p_push) else $error("push did not increment stack top");

	property p_pointer_high;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_sfr.wr && hit_high) |=> o_indirect_address_pointer[15:8] == $past(i_sfr.wdata);
	endproperty
	a_pointer_high: assert property (p_pointer_high) else $error("pointer high byte wrong");

	property p_carry;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_alu.carry_we |=> o_carry_flag == $past(i_alu.carry);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag not updated");

	property p_aux;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_alu.aux_we |=> program_status_word[`CCS_BIT_AUX] == $past(i_alu.aux);
	endproperty
	a_aux: assert property (p_aux) else $error("auxiliary carry not updated");

	property p_bank;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_sfr.wr && hit_status && !bit_status) |=>
			o_bank_base == {$past(i_sfr.wdata[4:3]), `CCS_BANK_LOW};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base does not follow select bits");

	property p_excess;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_alu.excess_we |=> program_status_word[`CCS_BIT_EXCESS] == $past(i_alu.excess);
	endproperty
	a_excess: assert property (p_excess) else $error("overflow flag not updated");

	property p_parity;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_sfr.rd && hit_status) |=>
			o_sfr_rdata[`CCS_BIT_PARITY] == ^$past(main_operand_register);
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");

	property p_parity_out;
		@(posedge i_mclk) disable iff (!i_rst_n)
		o_parity == ^o_main_operand;
	endproperty
	a_parity_out: assert property (p_parity_out) else $error("parity output wrong");

	property p_user_bit;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(bit_status && i_bit.addr[2:0] == `CCS_BIT_USER_ZERO && !i_sfr.wr) |=>
			program_status_word[`CCS_BIT_USER_ZERO] == $past(i_bit.value);
	endproperty
	a_user_bit: assert property (p_user_bit) else $error("user flag bit write lost");

	property p_second_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_sfr.wr && hit_second && !bit_second) |=> o_second_operand == $past(i_sfr.wdata);
	endproperty
	a_second_write: assert property (p_second_write) else $error("second operand write lost");

	property p_read_stack;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_sfr.rd && hit_stack) |=> o_sfr_ack && o_sfr_rdata == $past(stack_top_pointer);
	endproperty
	a_read_stack: assert property (p_read_stack) else $error("stack top read wrong");

endmodule : ccs_core_status

// [tb/test_cpu_core_status_registers.sv]
// self-checking bench of the core status register block
`timescale 1ns/1ps
module test_cpu_core_status_registers;
	import ccs_pkg::*;
	logic              i_mclk;
	logic              i_rst_n;
	ccs_sfr_req_type   i_sfr;
	ccs_bit_req_type   i_bit;
	logic              i_push;
	logic              i_pop;
	ccs_alu_flags_type i_alu;
	logic              i_main_we;
	logic [7:0]        i_main_wdata;
	logic              i_second_we;
	logic [7:0]        i_second_wdata;
	logic              o_sfr_hit;
	logic              o_sfr_ack;
	logic [7:0]        o_sfr_rdata;
	logic [7:0]        o_stack_top;
	logic [15:0]       o_indirect_address_pointer;
	logic [4:0]        o_bank_base;
	logic [7:0]        o_main_operand;
	logic [7:0]        o_second_operand;
	logic              o_carry_flag;
	logic              o_parity;
	int                n_mismatch = 0;
	int                checks_done = 0;
	logic [7:0]        map_addr [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
	logic [7:0]        map_rst [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	ccs_core_status i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr(i_sfr), .i_bit(i_bit),
		.o_sfr_hit(o_sfr_hit), .o_sfr_ack(o_sfr_ack), .o_sfr_rdata(o_sfr_rdata),
		.i_push(i_push), .i_pop(i_pop), .i_alu(i_alu), .i_main_we(i_main_we),
		.i_main_wdata(i_main_wdata), .i_second_we(i_second_we),
		.i_second_wdata(i_second_wdata),
		.o_stack_top(o_stack_top), .o_indirect_address_pointer(o_indirect_address_pointer),
		.o_bank_base(o_bank_base), .o_main_operand(o_main_operand),
		.o_second_operand(o_second_operand), .o_carry_flag(o_carry_flag), .o_parity(o_parity));

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	task automatic end_sim;
		if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick;
		@(posedge i_mclk);
		@(negedge i_mclk);
	endtask : tick

	// each transfer ends with one idle edge so two requests never abut
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr = {1'b1, 1'b0, a, d};
		tick();
		i_sfr = '0;
		tick();
	endtask : sfr_wr

	// a read is answered with ack and data one cycle after it is taken
	task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		i_sfr = {1'b0, 1'b1, a, 8'h00};
		#1 chk("hit", {15'h0, hit}, {15'h0, o_sfr_hit});
		tick();
		i_sfr = '0;
		chk("ack", {15'h0, hit}, {15'h0, o_sfr_ack});
		chk("rdata", {8'h00, exp}, {8'h00, o_sfr_rdata});
		tick();
		chk("ack_end", 16'h0000, {15'h0, o_sfr_ack});
	endtask : sfr_rd

	task automatic bit_wr(input logic [7:0] a, input logic v);
		i_bit = {1'b1, a, v};
		tick();
		i_bit = '0;
		tick();
	endtask : bit_wr

	task automatic alu(input logic [5:0] f);
		i_alu = f;
		tick();
		i_alu = '0;
		tick();
	endtask : alu

	initial begin
		repeat (2000) @(posedge i_mclk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		i_rst_n = 1'b0;
		{i_sfr, i_bit, i_push, i_pop, i_alu, i_main_we, i_main_wdata, i_second_we,
			i_second_wdata} = '0;
		repeat (3) @(negedge i_mclk);
		i_rst_n = 1'b1;
		chk("stack", 16'h0007, {8'h00, o_stack_top});
		for (int k = 0; k < 6; k++) sfr_rd(map_addr[k], map_rst[k], 1'b1);
		sfr_rd(8'h84, 8'h00, 1'b0);
		i_push = 1'b1;
		tick();
		chk("push", 16'h0008, {8'h00, o_stack_top});
		tick();
		i_push = 1'b0;
		chk("push2", 16'h0009, {8'h00, o_stack_top});
		i_pop = 1'b1;
		tick();
		i_pop = 1'b0;
		chk("pop", 16'h0008, {8'h00, o_stack_top});
		tick();
		// a stack pointer write wins over a push in the same cycle
		i_push = 1'b1;
		i_sfr = {1'b1, 1'b0, 8'h81, 8'h40};
		tick();
		i_push = 1'b0;
		i_sfr = '0;
		chk("stack_wr", 16'h0040, {8'h00, o_stack_top});
		tick();
		sfr_wr(8'h82, 8'h34);
		sfr_wr(8'h83, 8'h12);
		chk("pointer", 16'h1234, o_indirect_address_pointer);
		sfr_rd(8'h83, 8'h12, 1'b1);
		alu(6'b110000);
		chk("carry", 16'h0001, {15'h0, o_carry_flag});
		sfr_rd(8'hd0, 8'h80, 1'b1);
		alu(6'b001100);
		sfr_rd(8'hd0, 8'hc0, 1'b1);
		alu(6'b000011);
		sfr_rd(8'hd0, 8'hc4, 1'b1);
		alu(6'b101010);
		sfr_rd(8'hd0, 8'h00, 1'b1);
		// bank changes only touch defined bits and are never followed at once by a move
		for (int k = 0; k < 4; k++) begin
			sfr_wr(8'hd0, 8'(k << 3));
			chk("bank", 16'(k << 3), {11'h0, o_bank_base});
		end
		sfr_wr(8'he0, 8'h01);
		chk("parity", 16'h0001, {15'h0, o_parity});
		sfr_wr(8'hd0, 8'h00);
		sfr_rd(8'hd0, 8'h01, 1'b1);
		i_main_we = 1'b1;
		i_main_wdata = 8'h03;
		tick();
		i_main_we = 1'b0;
		chk("main", 16'h0003, {8'h00, o_main_operand});
		chk("parity_even", 16'h0000, {15'h0, o_parity});
		sfr_wr(8'hd0, 8'h01);
		sfr_rd(8'hd0, 8'h00, 1'b1);
		bit_wr(8'hd5, 1'b1);
		bit_wr(8'hd1, 1'b1);
		sfr_rd(8'hd0, 8'h22, 1'b1);
		bit_wr(8'hd5, 1'b0);
		sfr_rd(8'hd0, 8'h02, 1'b1);
		chk("bank_kept", 16'h0000, {11'h0, o_bank_base});
		sfr_wr(8'hf0, 8'h5a);
		bit_wr(8'hf7, 1'b1);
		sfr_rd(8'hf0, 8'hda, 1'b1);
		i_second_we = 1'b1;
		i_second_wdata = 8'h3c;
		tick();
		i_second_we = 1'b0;
		chk("second", 16'h003c, {8'h00, o_second_operand});
		// reset in mid-run brings every register back to its reset value
		i_rst_n = 1'b0;
		tick();
		i_rst_n = 1'b1;
		chk("stack_rst", 16'h0007, {8'h00, o_stack_top});
		sfr_rd(8'hf0, 8'h00, 1'b1);
		sfr_rd(8'hd0, 8'h00, 1'b1);
		end_sim();
	end
endmodule : test_cpu_core_status_registers
